// ===== design/spm_pin_mux.sv
// Overview of operation
// R1 - After reset all pins are plain inputs
// R2 - Port A 0,1: analog, timer, keyboard, port
// R3 - Port A 2: interrupt, timer clock, keyboard, port
// R4 - Port A 3: reset, keyboard, port
// R5 - Port A 4,5: oscillator, analog, keyboard, port
// R6 - Port B 0-3: analog, SPI, port
// R7 - Port B 4,5: analog, serial, port
// R8 - Port B 6,7: timer channel, else port
// R9 - Analog selection does not override other modules
// R10 - Transmit is output, receive is bidirectional
// R11 - Port A bit 2 never drives pin
// R12 - Owner resolved from enables; inputs fan out
module spm_pin_mux (
	input wire logic CLK_IN, // 10 MHz system clock
	input wire logic RST_IN, // Synchronous reset, active high
	// Pins
	input wire logic [spm_pkg::PORT_A_PINS-1:0] PA_PIN_IN, // Port A pin levels
	output logic [spm_pkg::PORT_A_PINS-1:0] PA_PIN_OUT, // Port A pin drive value
	output logic [spm_pkg::PORT_A_PINS-1:0] PA_PIN_OE_N_OUT, // Port A enable, low drives
	input wire logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_IN, // Port B pin levels
	output logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_OUT, // Port B pin drive value
	output logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_OE_N_OUT, // Port B enable, low drives
	// General port function
	input wire spm_pkg::spm_port_drive_s PA_PORT_IN, // Port A direction/data (low 6 used)
	input wire spm_pkg::spm_port_drive_s PB_PORT_IN, // Port B direction/data
	output logic [spm_pkg::PORT_A_PINS-1:0] PA_PORT_DATA_OUT, // Port A read value
	output logic [spm_pkg::PORT_B_PINS-1:0] PB_PORT_DATA_OUT, // Port B read value
	// Analog inputs
	input wire logic [spm_pkg::ANALOG_CHANNELS-1:0] ANALOG_EN_IN, // Analog channel selects
	output logic [spm_pkg::ANALOG_CHANNELS-1:0] ANALOG_CHANNEL_INPUT_OUT, // Level to converter
	// Timer channels
	input wire spm_pkg::spm_func_s [spm_pkg::TIMER_CHANNELS-1:0] TIMER_CH_IN, // Channel drive requests
	output logic [spm_pkg::TIMER_CHANNELS-1:0] TIMER_CHANNEL_PIN_OUT, // Channel capture inputs
	input wire logic TIMER_CLK_EN_IN, // Timer external clock selected
	output logic TIMER_CLOCK_INPUT_OUT, // External timer clock level
	// Keyboard
	input wire logic [spm_pkg::KEYBOARD_INPUTS-1:0] KBD_EN_IN, // Keyboard input enables
	output logic [spm_pkg::KEYBOARD_INPUTS-1:0] KEYBOARD_INTERRUPT_INPUT_OUT, // Keyboard levels
	// System functions
	input wire logic EXT_IRQ_EN_IN, // External interrupt pin enabled
	output logic EXT_IRQ_OUT, // External interrupt level
	input wire logic EXT_RESET_EN_IN, // Reset pin function enabled
	output logic EXT_RESET_N_OUT, // Reset pin level, active low
	input wire logic OSC_IN_EN_IN, // Oscillator input pin in use
	output logic OSCILLATOR_INPUT_PIN_OUT, // Oscillator input level
	input wire logic OSC_OUT_EN_IN, // Oscillator output pin in use
	input wire logic OSC_OUT_VAL_IN, // Oscillator output level
	// SPI
	input wire spm_pkg::spm_func_s [spm_pkg::SPI_PINS-1:0] SPI_IN, // Clock, MOSI, MISO, select
	output logic [spm_pkg::SPI_PINS-1:0] SPI_PIN_OUT, // SPI pin levels
	// Serial interface
	input wire spm_pkg::spm_func_s SER_RX_IN, // Receive pin request
	input wire logic SER_TX_EN_IN, // Transmitter enabled
	input wire logic SER_TX_VAL_IN, // Transmit level
	output logic SER_RX_OUT // Receive level
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Pins are asynchronous: three stages, a change counts when 2 and 3 agree
	logic [spm_pkg::PORT_A_PINS-1:0] pa_s1_reg, pa_s2_reg, pa_s3_reg, pa_clean_reg;
	logic [spm_pkg::PORT_B_PINS-1:0] pb_s1_reg, pb_s2_reg, pb_s3_reg, pb_clean_reg;
	logic [spm_pkg::PORT_A_PINS-1:0] pa_clean_next;
	logic [spm_pkg::PORT_B_PINS-1:0] pb_clean_next;

	// Accept a new level only when the two later stages agree
	always_comb begin
		pa_clean_next = pa_clean_reg;
		pb_clean_next = pb_clean_reg;
		for (int i = 0; i < spm_pkg::PORT_A_PINS; i++) begin
			if (pa_s2_reg[i] == pa_s3_reg[i]) begin
				pa_clean_next[i] = pa_s3_reg[i];
			end
		end
		for (int i = 0; i < spm_pkg::PORT_B_PINS; i++) begin
			if (pb_s2_reg[i] == pb_s3_reg[i]) begin
				pb_clean_next[i] = pb_s3_reg[i];
			end
		end
	end

	// Sync chain registers
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pa_s1_reg <= spm_pkg::PA_ZERO;
			pa_s2_reg <= spm_pkg::PA_ZERO;
			pa_s3_reg <= spm_pkg::PA_ZERO;
			pa_clean_reg <= spm_pkg::PA_ZERO;
			pb_s1_reg <= spm_pkg::PB_ZERO;
			pb_s2_reg <= spm_pkg::PB_ZERO;
			pb_s3_reg <= spm_pkg::PB_ZERO;
			pb_clean_reg <= spm_pkg::PB_ZERO;
		end else begin
			pa_s1_reg <= PA_PIN_IN;
			pa_s2_reg <= pa_s1_reg;
			pa_s3_reg <= pa_s2_reg;
			pa_clean_reg <= pa_clean_next;
			pb_s1_reg <= PB_PIN_IN;
			pb_s2_reg <= pb_s1_reg;
			pb_s3_reg <= pb_s2_reg;
			pb_clean_reg <= pb_clean_next;
		end
	end

	// ************************************************************
	// Ownership resolution
	// ************************************************************
	spm_pkg::spm_owner_e pa_owner [spm_pkg::PORT_A_PINS];
	spm_pkg::spm_owner_e pb_owner [spm_pkg::PORT_B_PINS];
	logic [spm_pkg::PORT_A_PINS-1:0] pa_oe_n_next, pa_val_next;
	logic [spm_pkg::PORT_B_PINS-1:0] pb_oe_n_next, pb_val_next;

	// Port A priority chains; analog owner never drives so it overrides nothing
	always_comb begin
		for (int i = 0; i < spm_pkg::PORT_A_PINS; i++) begin
			pa_owner[i] = spm_pkg::SPM_OWN_PORT;
			if (i == spm_pkg::PA_BIT2) begin
				if (EXT_IRQ_EN_IN) pa_owner[i] = spm_pkg::SPM_OWN_SYS; // R3
				else if (TIMER_CLK_EN_IN) pa_owner[i] = spm_pkg::SPM_OWN_TIMER; // R3
				else if (KBD_EN_IN[i]) pa_owner[i] = spm_pkg::SPM_OWN_KBD; // R3
			end else if (i == spm_pkg::PA_BIT3) begin
				if (EXT_RESET_EN_IN) pa_owner[i] = spm_pkg::SPM_OWN_SYS; // R4
				else if (KBD_EN_IN[i]) pa_owner[i] = spm_pkg::SPM_OWN_KBD; // R4
			end else if (i >= spm_pkg::PA_BIT4) begin
				if ((i == spm_pkg::PA_BIT4) ? OSC_OUT_EN_IN : OSC_IN_EN_IN) begin
					pa_owner[i] = spm_pkg::SPM_OWN_SYS; // R5
				end else if (ANALOG_EN_IN[i - spm_pkg::PA_BIT4 + spm_pkg::AN_PA_OSC]) begin
					pa_owner[i] = spm_pkg::SPM_OWN_ANALOG; // R5
				end else if (KBD_EN_IN[i]) begin
					pa_owner[i] = spm_pkg::SPM_OWN_KBD; // R5
				end
			end else begin
				if (ANALOG_EN_IN[i + spm_pkg::AN_PA_LOW]) pa_owner[i] = spm_pkg::SPM_OWN_ANALOG; // R2
				else if (TIMER_CH_IN[i].en) pa_owner[i] = spm_pkg::SPM_OWN_TIMER; // R2
				else if (KBD_EN_IN[i]) pa_owner[i] = spm_pkg::SPM_OWN_KBD; // R2
			end
		end
	end

	// Port A drive; analog owner falls through to lower enabled drivers
	always_comb begin
		for (int i = 0; i < spm_pkg::PORT_A_PINS; i++) begin
			pa_oe_n_next[i] = ~PA_PORT_IN.dir_out[i];
			pa_val_next[i] = PA_PORT_IN.data[i];
			if (i == spm_pkg::PA_BIT2) begin
				pa_oe_n_next[i] = 1'b1; // R11
				pa_val_next[i] = 1'b0; // R11
			end else if (pa_owner[i] == spm_pkg::SPM_OWN_SYS) begin
				pa_oe_n_next[i] = ~(i == spm_pkg::PA_BIT4); // R5
				pa_val_next[i] = (i == spm_pkg::PA_BIT4) & OSC_OUT_VAL_IN; // R5
			end else if (pa_owner[i] == spm_pkg::SPM_OWN_KBD) begin
				pa_oe_n_next[i] = 1'b1; // R12
				pa_val_next[i] = 1'b0;
			end else if (i < spm_pkg::PA_BIT2 && TIMER_CH_IN[i].en) begin
				// Timer wins over port even when analog is selected
				pa_oe_n_next[i] = ~TIMER_CH_IN[i].oe; // R9
				pa_val_next[i] = TIMER_CH_IN[i].val; // R9
			end else if (pa_owner[i] == spm_pkg::SPM_OWN_ANALOG && i >= spm_pkg::PA_BIT4 && KBD_EN_IN[i]) begin
				pa_oe_n_next[i] = 1'b1; // R9
				pa_val_next[i] = 1'b0;
			end else if (pa_owner[i] == spm_pkg::SPM_OWN_ANALOG && i < spm_pkg::PA_BIT2 && KBD_EN_IN[i]) begin
				pa_oe_n_next[i] = 1'b1; // R9
				pa_val_next[i] = 1'b0;
			end
		end
	end

	// Port B priority chains and drive
	always_comb begin
		for (int i = 0; i < spm_pkg::PORT_B_PINS; i++) begin
			pb_owner[i] = spm_pkg::SPM_OWN_PORT;
			pb_oe_n_next[i] = ~PB_PORT_IN.dir_out[i];
			pb_val_next[i] = PB_PORT_IN.data[i];
			if (i >= spm_pkg::PB_BIT6) begin
				if (TIMER_CH_IN[i - spm_pkg::PB_BIT6 + spm_pkg::TIMER_PB_BASE].en) begin
					pb_owner[i] = spm_pkg::SPM_OWN_TIMER; // R8
					pb_oe_n_next[i] = ~TIMER_CH_IN[i - spm_pkg::PB_BIT6 + spm_pkg::TIMER_PB_BASE].oe; // R8
					pb_val_next[i] = TIMER_CH_IN[i - spm_pkg::PB_BIT6 + spm_pkg::TIMER_PB_BASE].val; // R8
				end
			end else begin
				if (ANALOG_EN_IN[i + spm_pkg::AN_PB]) pb_owner[i] = spm_pkg::SPM_OWN_ANALOG; // R6
				else if (i < spm_pkg::PB_BIT4 && SPI_IN[i].en) pb_owner[i] = spm_pkg::SPM_OWN_SERIAL; // R6
				else if (i == spm_pkg::PB_BIT4 && SER_RX_IN.en) pb_owner[i] = spm_pkg::SPM_OWN_SERIAL; // R7
				else if (i == spm_pkg::PB_BIT5 && SER_TX_EN_IN) pb_owner[i] = spm_pkg::SPM_OWN_SERIAL; // R7
				// Analog does not block the peripheral underneath
				if (i < spm_pkg::PB_BIT4 && SPI_IN[i].en) begin
					pb_oe_n_next[i] = ~SPI_IN[i].oe; // R9
					pb_val_next[i] = SPI_IN[i].val; // R6
				end else if (i == spm_pkg::PB_BIT4 && SER_RX_IN.en) begin
					pb_oe_n_next[i] = ~SER_RX_IN.oe; // R10
					pb_val_next[i] = SER_RX_IN.val; // R10
				end else if (i == spm_pkg::PB_BIT5 && SER_TX_EN_IN) begin
					pb_oe_n_next[i] = 1'b0; // R10
					pb_val_next[i] = SER_TX_VAL_IN; // R10
				end
			end
		end
	end

	// ************************************************************
	// Output registers
	// ************************************************************
	// Every pin is released at reset regardless of enables
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			PA_PIN_OE_N_OUT <= spm_pkg::PA_OE_N_RESET; // R1
			PA_PIN_OUT <= spm_pkg::PA_ZERO; // R1
			PB_PIN_OE_N_OUT <= spm_pkg::PB_OE_N_RESET; // R1
			PB_PIN_OUT <= spm_pkg::PB_ZERO; // R1
		end else begin
			PA_PIN_OE_N_OUT <= pa_oe_n_next; // R12
			PA_PIN_OUT <= pa_val_next;
			PB_PIN_OE_N_OUT <= pb_oe_n_next; // R12
			PB_PIN_OUT <= pb_val_next;
		end
	end

	// Inputs reach every listener but the reset level whether or not it owns the pin
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			PA_PORT_DATA_OUT <= spm_pkg::PA_ZERO;
			PB_PORT_DATA_OUT <= spm_pkg::PB_ZERO;
			ANALOG_CHANNEL_INPUT_OUT <= '0;
			TIMER_CHANNEL_PIN_OUT <= '0;
			TIMER_CLOCK_INPUT_OUT <= 1'b0;
			KEYBOARD_INTERRUPT_INPUT_OUT <= '0;
			EXT_IRQ_OUT <= 1'b0;
			EXT_RESET_N_OUT <= 1'b1;
			OSCILLATOR_INPUT_PIN_OUT <= 1'b0;
			SPI_PIN_OUT <= '0;
			SER_RX_OUT <= 1'b1;
		end else begin
			PA_PORT_DATA_OUT <= pa_clean_reg; // R12
			PB_PORT_DATA_OUT <= pb_clean_reg; // R12
			ANALOG_CHANNEL_INPUT_OUT <= {pb_clean_reg[spm_pkg::PB_BIT5:0],
				pa_clean_reg[spm_pkg::PA_BIT5:spm_pkg::PA_BIT4], pa_clean_reg[1:0]};
			TIMER_CHANNEL_PIN_OUT <= {pb_clean_reg[spm_pkg::PB_BIT7:spm_pkg::PB_BIT6], pa_clean_reg[1:0]};
			TIMER_CLOCK_INPUT_OUT <= pa_clean_reg[spm_pkg::PA_BIT2];
			KEYBOARD_INTERRUPT_INPUT_OUT <= pa_clean_reg;
			EXT_IRQ_OUT <= pa_clean_reg[spm_pkg::PA_BIT2];
			// Reset level reads high unless the function is enabled
			EXT_RESET_N_OUT <= ~EXT_RESET_EN_IN | pa_clean_reg[spm_pkg::PA_BIT3]; // R4
			OSCILLATOR_INPUT_PIN_OUT <= pa_clean_reg[spm_pkg::PA_BIT5];
			SPI_PIN_OUT <= pb_clean_reg[spm_pkg::SPI_PINS-1:0];
			SER_RX_OUT <= pb_clean_reg[spm_pkg::PB_BIT4];
		end
	end

endmodule // spm_pin_mux

// ===== design/spm_pkg.sv
package spm_pkg;

	// ************************************************************
	// Pin counts and layout
	// ************************************************************
	localparam int PORT_A_PINS = 6; // Port A bits 0..5
	localparam int PORT_B_PINS = 8; // Port B bits 0..7
	localparam int ANALOG_CHANNELS = 10; // Analog channels 0..9
	localparam int KEYBOARD_INPUTS = 6; // Keyboard inputs 0..5
	localparam int TIMER_CHANNELS = 4; // Timer channels 0..3
	localparam int SPI_PINS = 4; // Clock, MOSI, MISO, select

	// Port A pin positions
	localparam int PA_BIT2 = 2; // Interrupt / timer clock pin
	localparam int PA_BIT3 = 3; // Reset pin
	localparam int PA_BIT4 = 4; // Oscillator output pin
	localparam int PA_BIT5 = 5; // Oscillator input pin
	// Port B pin positions
	localparam int PB_BIT4 = 4; // Serial receive pin
	localparam int PB_BIT5 = 5; // Serial transmit pin
	localparam int PB_BIT6 = 6; // Timer channel 2 pin
	localparam int PB_BIT7 = 7; // Timer channel 3 pin

	// Analog and timer channel offsets
	localparam int AN_PA_LOW = 0; // Port A bits 0,1 -> channels 0,1
	localparam int AN_PA_OSC = 2; // Port A bits 4,5 -> channels 2,3
	localparam int AN_PB = 4; // Port B bits 0..5 -> channels 4..9
	localparam int TIMER_PB_BASE = 2; // Timer channels 2,3 on port B 6,7

	// Reset values: output enable is active low, so all ones means all input
	localparam logic [PORT_A_PINS-1:0] PA_OE_N_RESET = 6'h3F;
	localparam logic [PORT_B_PINS-1:0] PB_OE_N_RESET = 8'hFF;
	localparam logic [PORT_A_PINS-1:0] PA_ZERO = 6'h00;
	localparam logic [PORT_B_PINS-1:0] PB_ZERO = 8'h00;

	// ************************************************************
	// Grouped carriers
	// ************************************************************
	// Enables and drive of one port from its general function
	typedef struct packed {
		logic [PORT_B_PINS-1:0] dir_out; // 1 = port drives pin
		logic [PORT_B_PINS-1:0] data; // Port output latch
	} spm_port_drive_s;

	// Drive request of a bidirectional peripheral pin
	typedef struct packed {
		logic en; // Function enabled
		logic oe; // Function wants to drive
		logic val; // Value it drives
	} spm_func_s;

	// Owner of a pin after priority resolution
	typedef enum logic [2:0] {
		SPM_OWN_PORT,
		SPM_OWN_ANALOG,
		SPM_OWN_TIMER,
		SPM_OWN_KBD,
		SPM_OWN_SYS,
		SPM_OWN_SERIAL
	} spm_owner_e;

endpackage

// ===== sim/shared_pin_priority_mux_tb_top.sv
module shared_pin_priority_mux_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// Stimulus, pins and counters
	// ************************************************************
	logic clk_in = 1'b0; // 10 MHz
	logic rst_in = 1'b1; // Sync reset
	spm_pkg::spm_port_drive_s pa_port = '0; // Port A latch
	spm_pkg::spm_port_drive_s pb_port = '0; // Port B latch
	spm_pkg::spm_func_s [3:0] tim = '0; // Timer requests
	spm_pkg::spm_func_s [3:0] spi = '0; // SPI requests
	spm_pkg::spm_func_s rx = '0; // Receive request
	logic [9:0] an_en = '0; // Analog selects
	logic [5:0] kbd_en = '0; // Keyboard enables
	logic [7:0] ctl = '0; // irq, rst pin, timer_clock_input, osc in, osc out, osc val, tx en, tx val
	logic [13:0] ext_en = '0; // Board drive enables
	logic [13:0] ext_val = '0; // Board levels
	logic [5:0] pa_oe_n, pa_out, pa_data; // Port A results
	logic [7:0] pb_oe_n, pb_out, pb_data; // Port B results
	logic [9:0] an_out; // Analog levels
	logic [3:0] tp_out; // Timer capture levels
	logic [13:0] lv; // Line levels
	logic timer_clock_input_o, irq_o, rstn_o, osc_o, rx_o; // Single listener levels
	logic [5:0] kbd_o; // Keyboard levels
	logic [3:0] spi_o; // SPI levels
	int failures = 0; // Mismatches
	int comparisons = 0; // Checks made
	always #50 clk_in = ~clk_in;
	spm_pin_mux spm_pin_mux_inst (
		.CLK_IN(clk_in), .RST_IN(rst_in), .PA_PIN_IN(lv[5:0]), .PA_PIN_OUT(pa_out), .PA_PIN_OE_N_OUT(pa_oe_n),
		.PB_PIN_IN(lv[13:6]), .PB_PIN_OUT(pb_out), .PB_PIN_OE_N_OUT(pb_oe_n), .PA_PORT_IN(pa_port),
		.PB_PORT_IN(pb_port), .PA_PORT_DATA_OUT(pa_data), .PB_PORT_DATA_OUT(pb_data), .ANALOG_EN_IN(an_en),
		.ANALOG_CHANNEL_INPUT_OUT(an_out), .TIMER_CH_IN(tim), .TIMER_CHANNEL_PIN_OUT(tp_out),
		.TIMER_CLK_EN_IN(ctl[5]), .TIMER_CLOCK_INPUT_OUT(timer_clock_input_o), .KBD_EN_IN(kbd_en),
		.KEYBOARD_INTERRUPT_INPUT_OUT(kbd_o), .EXT_IRQ_EN_IN(ctl[7]), .EXT_IRQ_OUT(irq_o),
		.EXT_RESET_EN_IN(ctl[6]), .EXT_RESET_N_OUT(rstn_o), .OSC_IN_EN_IN(ctl[4]), .OSCILLATOR_INPUT_PIN_OUT(osc_o),
		.OSC_OUT_EN_IN(ctl[3]), .OSC_OUT_VAL_IN(ctl[2]), .SPI_IN(spi), .SPI_PIN_OUT(spi_o), .SER_RX_IN(rx),
		.SER_TX_EN_IN(ctl[1]), .SER_TX_VAL_IN(ctl[0]), .SER_RX_OUT(rx_o));
	spm_board_model spm_board_model_inst (.clk_in(clk_in), .oe_n_in({pb_oe_n, pa_oe_n}),
		.dev_val_in({pb_out, pa_out}), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lv));
	// ************************************************************
	// Tasks
	// ************************************************************
	// One compare, counted and reported
	task automatic check(input logic [27:0] got, input logic [27:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Reset with every function but analog and keyboard requesting the pins
	task automatic do_reset();
		@(posedge clk_in);
		rst_in <= 1'b1;
		{tim, spi, rx, ctl} <= 35'h7FFFFFFFF;
		{pa_port, pb_port} <= 32'hFFFFFFFF;
		repeat (1) @(posedge clk_in);
		@(negedge clk_in);
		check({pb_oe_n, pa_oe_n, pb_out, pa_out}, 28'hFFFC000);
		check({pb_data, pa_data, an_out, tp_out}, 28'h0000000);
		check({13'h0, kbd_o, spi_o, timer_clock_input_o, irq_o, rstn_o, osc_o, rx_o}, 28'h0000005);
		@(posedge clk_in);
		rst_in <= 1'b0;
	endtask
	// New random request set; board mostly drives its lines
	task automatic randomise();
		@(posedge clk_in);
		{pa_port, pb_port} <= $urandom;
		{tim, spi, rx, ctl[4:0]} <= $urandom;
		{an_en, kbd_en, ctl[7:5]} <= 19'($urandom);
		ext_en <= 14'($urandom) | 14'($urandom);
		ext_val <= 14'($urandom);
	endtask
	// Reference owner model, applied lowest priority first
	task automatic verify();
		logic [13:0] drv, val, kn, lx;
		logic [14:0] msk;
		drv = {pb_port.dir_out, pa_port.dir_out[5:0]};
		val = {pb_port.data, pa_port.data[5:0]};
		for (int i = 0; i < 6; i++) if (kbd_en[i]) drv[i] = 1'b0;
		for (int i = 0; i < 2; i++) if (tim[i].en) {drv[i], val[i]} = {tim[i].oe, tim[i].val};
		drv[2] = 1'b0;
		if (ctl[6]) drv[3] = 1'b0;
		if (ctl[3]) {drv[4], val[4]} = {1'b1, ctl[2]};
		if (ctl[4]) drv[5] = 1'b0;
		for (int i = 0; i < 4; i++) if (spi[i].en) {drv[6+i], val[6+i]} = {spi[i].oe, spi[i].val};
		if (rx.en) {drv[10], val[10]} = {rx.oe, rx.val};
		if (ctl[1]) {drv[11], val[11]} = {1'b1, ctl[0]};
		for (int i = 2; i < 4; i++) if (tim[i].en) {drv[10+i], val[10+i]} = {tim[i].oe, tim[i].val};
		lx = (drv & val) | (~drv & ext_val);
		kn = drv | ext_en;
		check({pb_oe_n, pa_oe_n, pb_out & drv[13:6], pa_out & drv[5:0]}, {~drv, val & drv});
		check({pb_data, pa_data, an_out, tp_out} & {kn, kn[11:6], kn[5:4], kn[1:0], kn[13:12], kn[1:0]},
			{lx, lx[11:6], lx[5:4], lx[1:0], lx[13:12], lx[1:0]} & {kn, kn[11:6], kn[5:4], kn[1:0], kn[13:12], kn[1:0]});
		// Single listeners; the reset level reads high while its function is off
		msk = {kn[5:0], kn[9:6], kn[2], kn[2], ~ctl[6] | kn[3], kn[5], kn[10]};
		check({13'h0, {kbd_o, spi_o, timer_clock_input_o, irq_o, rstn_o, osc_o, rx_o} & msk},
			{13'h0, {lx[5:0], lx[9:6], lx[2], lx[2], ~ctl[6] | lx[3], lx[5], lx[10]} & msk});
	endtask
	// Counts, verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		void'($urandom(32'h27F6C0DD));
		do_reset();
		for (int n = 0; n < 80; n++) begin
			if (n == 40) do_reset();
			randomise();
			repeat (8) @(posedge clk_in);
			@(negedge clk_in);
			verify();
		end
		complete_run();
	end
	// About 726 cycles expected; allow well over twice that
	initial begin
		#200000;
		failures++;
		complete_run();
	end
endmodule // shared_pin_priority_mux_tb_top

// ===== sim/spm_board_model.sv
// ************************************************************
// Board side of the fourteen shared pins
// ************************************************************
module spm_board_model (
	input wire logic clk_in, // Bench clock
	input wire logic [13:0] oe_n_in, // Device enables, low drives
	input wire logic [13:0] dev_val_in, // Device levels
	input wire logic [13:0] ext_en_in, // Board drives line
	input wire logic [13:0] ext_val_in, // Board levels
	output logic [13:0] level_out // Resolved line levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic float_reg = 1'b0; // Undriven lines wander so no stale level looks valid
	// Toggle for floating lines
	always @(posedge clk_in) float_reg <= ~float_reg;
	// Device wins a clash; a line nobody drives is meaningless
	always_comb begin
		for (int i = 0; i < 14; i++) begin
			level_out[i] = !oe_n_in[i] ? dev_val_in[i] : (ext_en_in[i] ? ext_val_in[i] : float_reg ^ i[0]);
		end
	end
endmodule // spm_board_model

// ===== sim/spm_pin_mux_checker.sv
// ************************************************************
// Pin ownership checks seen from the top-level ports
// ************************************************************
module spm_pin_mux_checker (
	input wire logic CLK_IN, // System clock
	input wire logic RST_IN, // Sync reset
	input wire logic [spm_pkg::PORT_A_PINS-1:0] PA_PIN_OE_N_OUT, // Port A enable
	input wire logic [spm_pkg::PORT_A_PINS-1:0] PA_PIN_OUT, // Port A value
	input wire logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_OE_N_OUT, // Port B enable
	input wire logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_OUT, // Port B value
	input wire logic [spm_pkg::PORT_B_PINS-1:0] PB_PIN_IN, // Port B levels
	input wire logic [spm_pkg::PORT_B_PINS-1:0] PB_PORT_DATA_OUT, // Port B read
	input wire spm_pkg::spm_port_drive_s PB_PORT_IN, // Port B latch
	input wire spm_pkg::spm_func_s [spm_pkg::TIMER_CHANNELS-1:0] TIMER_CH_IN, // Timer
	input wire logic [spm_pkg::KEYBOARD_INPUTS-1:0] KBD_EN_IN, // Keyboard
	input wire logic EXT_RESET_EN_IN, // Reset pin
	input wire logic OSC_IN_EN_IN, // Osc input
	input wire logic OSC_OUT_EN_IN, // Osc output
	input wire logic OSC_OUT_VAL_IN, // Osc level
	input wire spm_pkg::spm_func_s [spm_pkg::SPI_PINS-1:0] SPI_IN, // SPI
	input wire logic SER_TX_EN_IN, // Transmit on
	input wire logic SER_TX_VAL_IN // Transmit level
);
	// All checks share one clock; reset cancels any pending attempt except in the reset check
	default clocking cb @(posedge CLK_IN);
	endclocking
	// Sampled reset, so an attempt on the release edge still sees the reset outputs as disabled
	default disable iff ($sampled(RST_IN));
	// Reset itself must be watched, so it is not its own disable
	AST_RESET_ALL_INPUT: assert property (disable iff (1'b0) RST_IN |=> (&PA_PIN_OE_N_OUT) && (&PB_PIN_OE_N_OUT))
		else $error("pin driven after reset edge");
	AST_PA2_NEVER_DRIVES: assert property (PA_PIN_OE_N_OUT[spm_pkg::PA_BIT2])
		else $error("input-only pin driven");
	AST_TIMER_OWNS_PA0: assert property (TIMER_CH_IN[0].en |=> PA_PIN_OE_N_OUT[0] == !$past(TIMER_CH_IN[0].oe)
		&& (PA_PIN_OE_N_OUT[0] || PA_PIN_OUT[0] == $past(TIMER_CH_IN[0].val))) else $error("timer lost pin");
	AST_KBD_OVER_PORT: assert property (!TIMER_CH_IN[1].en && KBD_EN_IN[1] |=> PA_PIN_OE_N_OUT[1])
		else $error("keyboard pin driven");
	AST_RESET_PIN_INPUT: assert property (EXT_RESET_EN_IN |=> PA_PIN_OE_N_OUT[spm_pkg::PA_BIT3])
		else $error("reset pin driven");
	AST_OSC_OUT_DRIVES: assert property (OSC_OUT_EN_IN |=> !PA_PIN_OE_N_OUT[4] && PA_PIN_OUT[4] == $past(OSC_OUT_VAL_IN))
		else $error("osc output wrong");
	AST_OSC_IN_RELEASES: assert property (OSC_IN_EN_IN |=> PA_PIN_OE_N_OUT[spm_pkg::PA_BIT5])
		else $error("osc input pin driven");
	AST_SPI_OWNS_PB0: assert property (SPI_IN[0].en |=> PB_PIN_OE_N_OUT[0] == !$past(SPI_IN[0].oe))
		else $error("spi clock pin wrong");
	AST_TX_DRIVES: assert property (SER_TX_EN_IN |=> !PB_PIN_OE_N_OUT[5] && PB_PIN_OUT[5] == $past(SER_TX_VAL_IN))
		else $error("transmit pin wrong");
	AST_PORT_OWNS_PB7: assert property (!TIMER_CH_IN[3].en |=> PB_PIN_OE_N_OUT[7] == !$past(PB_PORT_IN.dir_out[7]))
		else $error("port direction wrong");
	// Five edges of latency, seven stable samples leave margin
	AST_LEVEL_REACHES_PORT: assert property ($stable(PB_PIN_IN[1]) [*7] |-> PB_PORT_DATA_OUT[1] == PB_PIN_IN[1])
		else $error("pin level not read back");
endmodule // spm_pin_mux_checker

bind spm_pin_mux spm_pin_mux_checker spm_pin_mux_checker_inst (.CLK_IN, .RST_IN, .PA_PIN_OE_N_OUT, .PA_PIN_OUT,
	.PB_PIN_OE_N_OUT, .PB_PIN_OUT, .PB_PIN_IN, .PB_PORT_DATA_OUT, .PB_PORT_IN, .TIMER_CH_IN, .KBD_EN_IN,
	.EXT_RESET_EN_IN, .OSC_IN_EN_IN, .OSC_OUT_EN_IN, .OSC_OUT_VAL_IN, .SPI_IN, .SER_TX_EN_IN, .SER_TX_VAL_IN);
